// file: verilog/trgsq_top.sv
// Main trigger sequencer: states, indicators, holdoff, auto timeout
`timescale 1ns/10ps
module trgsq_top
   import trgsq_pkg::*;
#(
   parameter int unsigned HOLDOFF_MIN = HOLDOFF_MIN_CYC,
   parameter int unsigned HOLDOFF_MAX = HOLDOFF_MAX_CYC
)(
   input  wire logic                    mclk_in,
   input  wire logic                    rst_in,
   input  wire logic                    run_stop_in,
   input  wire logic                    force_trig_in,
   input  wire logic                    single_seq_in,
   input  wire logic                    free_run_in,
   input  wire logic                    fast_persist_in,
   input  wire logic                    multi_frame_in,
   input  wire logic                    auto_mode_in,
   input  wire logic                    trig_event_in,
   input  wire logic                    dly_trig_event_in,
   input  wire logic                    dly_enable_in,
   input  wire logic                    pretrig_done_in,
   input  wire logic                    posttrig_done_in,
   input  wire logic                    default_holdoff_in,
   input  wire logic        [CNT_W-1:0] holdoff_cycles_in,
   input  wire logic        [CNT_W-1:0] div_cycles_in,
   input  wire logic        [CNT_W-1:0] auto_timeout_cycles_in,
   input  wire trgsq_src_e              source_in,
   input  wire trgsq_cpl_e              coupling_in,
   input  wire logic signed [LVL_W-1:0] knob_level_in,
   input  wire logic                    knob_load_in,
   input  wire logic                    transistor_logic_preset_in,
   input  wire logic                    emitter_logic_preset_in,
   input  wire logic                    midpoint_level_request_in,
   input  wire trgsq_type_e             trig_type_in,
   input  wire logic                    pulse_is_glitch_width_in,
   input  wire logic signed [LVL_W-1:0] peak_max_in,
   input  wire logic signed [LVL_W-1:0] peak_min_in,
   input  wire logic        [LVL_W-1:0] mv_per_div_in,
   input  wire logic signed [LVL_W-1:0] dly_level_in,
   input  wire logic                    dly_load_in,
   output trgsq_status_s                status_out,
   output logic                         acq_start_out,
   output logic                         acq_forced_out,
   output logic                         acq_running_out,
   output logic                         single_mode_out,
   output trgsq_src_e                   eff_source_out,
   output trgsq_cpl_e                   eff_coupling_out,
   output logic signed [LVL_W-1:0]      main_level_out,
   output logic signed [LVL_W-1:0]      dly_level_out
);

   trgsq_state_e     state_r;
   trgsq_state_e     state_nxt;
   logic             running_r;
   logic             single_r;
   logic             seq_done;
   logic             fast_mode;
   logic             fire;
   logic             forced;
   logic [CNT_W-1:0] ho_cnt_r;
   logic [CNT_W-1:0] ho_target;
   logic [CNT_W-1:0] auto_cnt_r;
   logic             auto_expired;
   logic [CNT_W+2:0] dflt_ho;

   function automatic logic [CNT_W-1:0] sat_cnt(input logic [CNT_W+2:0] v);
      if (v > (CNT_W+3)'(HOLDOFF_MAX))
         return CNT_W'(HOLDOFF_MAX);
      else if (v < (CNT_W+3)'(HOLDOFF_MIN))
         return CNT_W'(HOLDOFF_MIN);
      else
         return v[CNT_W-1:0];
   endfunction

   assign fast_mode = fast_persist_in || multi_frame_in;

   // Default holdoff scales with timebase
   assign dflt_ho = (CNT_W+3)'(div_cycles_in) *
                    (CNT_W+3)'(DEFAULT_HO_DIVS);
   assign ho_target = default_holdoff_in ? sat_cnt(dflt_ho)
                      : sat_cnt((CNT_W+3)'(holdoff_cycles_in));

   assign auto_expired = auto_mode_in &&
                         (auto_cnt_r >= auto_timeout_cycles_in);

   // Manual trigger counts during fill or ready, never when stopped
   assign forced = force_trig_in && running_r &&
                   ((state_r == TRGSQ_PREFILL) ||
                    (state_r == TRGSQ_READY));
   // A stop request just taken must not launch a record
   assign fire = running_r && (state_r == TRGSQ_READY) &&
                 (trig_event_in || auto_expired);

   // Run/stop toggles in free run; in single mode it rearms one shot
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         running_r <= 1'b0;
      end else if (run_stop_in) begin
         running_r <= single_r ? 1'b1 : !running_r;
      end else if (seq_done && single_r) begin
         running_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in)
         single_r <= 1'b0;
      else if (fast_persist_in || free_run_in)
         single_r <= 1'b0;
      else if (single_seq_in)
         single_r <= 1'b1;
   end

   assign seq_done = (state_r == TRGSQ_HOLDOFF) &&
                     (ho_cnt_r >= ho_target - 1'b1);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         TRGSQ_STOPPED:
            if (fast_mode && running_r)
               state_nxt = TRGSQ_FAST;
            else if (running_r)
               state_nxt = TRGSQ_PREFILL;
         TRGSQ_PREFILL:
            if (forced)
               state_nxt = TRGSQ_TRIGD;
            else if (pretrig_done_in)
               state_nxt = TRGSQ_READY;
         TRGSQ_READY:
            if (forced || fire)
               state_nxt = dly_enable_in ? TRGSQ_DLY_WAIT : TRGSQ_TRIGD;
         TRGSQ_DLY_WAIT:
            if (dly_trig_event_in)
               state_nxt = TRGSQ_TRIGD;
         TRGSQ_TRIGD:
            if (posttrig_done_in)
               state_nxt = TRGSQ_HOLDOFF;
         TRGSQ_HOLDOFF:
            if (seq_done)
               state_nxt = (single_r || !running_r) ? TRGSQ_STOPPED
                                                    : TRGSQ_PREFILL;
         TRGSQ_FAST:
            if (!fast_mode || !running_r)
               state_nxt = TRGSQ_STOPPED;
         default:
            state_nxt = TRGSQ_STOPPED;
      endcase
      // Stop request aborts a record unless still finishing holdoff
      if (!running_r && (state_r != TRGSQ_HOLDOFF))
         state_nxt = TRGSQ_STOPPED;
      if (running_r && fast_mode && (state_r != TRGSQ_FAST))
         state_nxt = TRGSQ_FAST;
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in)
         state_r <= TRGSQ_STOPPED;
      else
         state_r <= state_nxt;
   end

   // Holdoff counter runs only in holdoff state
   always_ff @(posedge mclk_in) begin
      if (rst_in || (state_r != TRGSQ_HOLDOFF))
         ho_cnt_r <= '0;
      else if (!seq_done)
         ho_cnt_r <= ho_cnt_r + 1'b1;
   end

   // Auto timer restarts on every trigger event
   always_ff @(posedge mclk_in) begin
      if (rst_in || trig_event_in || (state_r != TRGSQ_READY))
         auto_cnt_r <= '0;
      else if (!auto_expired)
         auto_cnt_r <= auto_cnt_r + 1'b1;
   end

   // Start strobe registered; forced flag marks untriggered records
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         acq_start_out  <= 1'b0;
         acq_forced_out <= 1'b0;
      end else begin
         acq_start_out  <= forced || fire;
         acq_forced_out <= forced || (fire && !trig_event_in);
      end
   end

   assign acq_running_out = running_r;
   assign single_mode_out = single_r;

   // Single decode avoids glitch combinations
   always_comb begin
      status_out = '0;
      unique case (state_r)
         TRGSQ_STOPPED:  status_out = 3'b000;
         TRGSQ_PREFILL:  status_out = 3'b001;
         TRGSQ_READY:    status_out = 3'b010;
         TRGSQ_TRIGD:    status_out = 3'b100;
         TRGSQ_DLY_WAIT: status_out = 3'b110;
         TRGSQ_HOLDOFF:  status_out = 3'b100;
         TRGSQ_FAST:     status_out = 3'b111;
         default:        status_out = 3'b000;
      endcase
   end

   // Source and coupling override
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         eff_source_out   <= TRGSQ_SRC_CH1;
         eff_coupling_out <= TRGSQ_CPL_DC;
      end else begin
         eff_source_out <= (source_in > TRGSQ_SRC_AUX) ? eff_source_out
                                                       : source_in;
         if (source_in == TRGSQ_SRC_LINE)
            eff_coupling_out <= TRGSQ_CPL_AC;
         else if (source_in == TRGSQ_SRC_AUX)
            eff_coupling_out <= TRGSQ_CPL_DC;
         else
            eff_coupling_out <= coupling_in;
      end
   end

   trgsq_level u_level (
      .mclk_in                    (mclk_in),
      .rst_in                     (rst_in),
      .knob_level_in              (knob_level_in),
      .knob_load_in               (knob_load_in),
      .transistor_logic_preset_in (transistor_logic_preset_in),
      .emitter_logic_preset_in    (emitter_logic_preset_in),
      .midpoint_level_request_in  (midpoint_level_request_in),
      .trig_type_in               (trig_type_in),
      .pulse_is_glitch_width_in   (pulse_is_glitch_width_in),
      .peak_max_in                (peak_max_in),
      .peak_min_in                (peak_min_in),
      .mv_per_div_in              (mv_per_div_in),
      .dly_level_in               (dly_level_in),
      .dly_load_in                (dly_load_in),
      .main_level_out             (main_level_out),
      .dly_level_out              (dly_level_out)
   );

endmodule

// file: pkg/trgsq_pkg.sv
// Shared constants and types for the trigger sequencer
package trgsq_pkg;

   localparam int unsigned CLK_FREQ_HZ      = 20_000_000;
   localparam int unsigned CLK_PERIOD_NS    = 50;
   localparam int unsigned HOLDOFF_MIN_NS   = 250;
   localparam int unsigned HOLDOFF_MAX_S    = 12;
   // Least time rounds up to whole cycles
   localparam int unsigned HOLDOFF_MIN_CYC  =
      (HOLDOFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Longest time rounds down
   localparam int unsigned HOLDOFF_MAX_CYC  = HOLDOFF_MAX_S * CLK_FREQ_HZ;
   localparam int unsigned DEFAULT_HO_DIVS  = 5;
   localparam int unsigned CNT_W            = 32;

   // Trigger level in millivolts, signed
   localparam int unsigned LVL_W            = 16;
   localparam logic signed [15:0] TTL_LEVEL_MV = 16'sh0578;   // +1400
   localparam logic signed [15:0] ECL_LEVEL_MV = -16'sh0514;  // -1300
   localparam int unsigned CLAMP_DIVS       = 12;

   typedef enum logic [2:0] {
      TRGSQ_STOPPED   = 3'b000,
      TRGSQ_PREFILL   = 3'b001,
      TRGSQ_READY     = 3'b010,
      TRGSQ_TRIGD     = 3'b011,
      TRGSQ_DLY_WAIT  = 3'b100,
      TRGSQ_HOLDOFF   = 3'b101,
      TRGSQ_FAST      = 3'b110
   } trgsq_state_e;

   typedef enum logic [2:0] {
      TRGSQ_SRC_CH1  = 3'b000,
      TRGSQ_SRC_CH2  = 3'b001,
      TRGSQ_SRC_CH3  = 3'b010,
      TRGSQ_SRC_CH4  = 3'b011,
      TRGSQ_SRC_LINE = 3'b100,
      TRGSQ_SRC_AUX  = 3'b101
   } trgsq_src_e;

   typedef enum logic [2:0] {
      TRGSQ_CPL_DC    = 3'b000,
      TRGSQ_CPL_AC    = 3'b001,
      TRGSQ_CPL_HIFRQ = 3'b010,
      TRGSQ_CPL_LOFRQ = 3'b011,
      TRGSQ_CPL_NREJ  = 3'b100
   } trgsq_cpl_e;

   typedef enum logic [1:0] {
      TRGSQ_TYPE_EDGE  = 2'b00,
      TRGSQ_TYPE_PULSE = 2'b01,
      TRGSQ_TYPE_LOGIC = 2'b10,
      TRGSQ_TYPE_VIDEO = 2'b11
   } trgsq_type_e;

   typedef struct packed {
      logic trigd;
      logic ready;
      logic arm;
   } trgsq_status_s;

endpackage

// file: verilog/trgsq_level.sv
// Trigger level presets, midpoint request and clamp
`timescale 1ns/10ps
module trgsq_level
   import trgsq_pkg::*;
(
   input  wire logic                    mclk_in,
   input  wire logic                    rst_in,
   input  wire logic signed [LVL_W-1:0] knob_level_in,
   input  wire logic                    knob_load_in,
   input  wire logic                    transistor_logic_preset_in,
   input  wire logic                    emitter_logic_preset_in,
   input  wire logic                    midpoint_level_request_in,
   input  wire trgsq_type_e             trig_type_in,
   input  wire logic                    pulse_is_glitch_width_in,
   input  wire logic signed [LVL_W-1:0] peak_max_in,
   input  wire logic signed [LVL_W-1:0] peak_min_in,
   input  wire logic        [LVL_W-1:0] mv_per_div_in,
   input  wire logic signed [LVL_W-1:0] dly_level_in,
   input  wire logic                    dly_load_in,
   output logic signed [LVL_W-1:0]      main_level_out,
   output logic signed [LVL_W-1:0]      dly_level_out
);

   logic signed [LVL_W+5:0] lim;
   logic signed [LVL_W:0]   mid;
   logic                    mid_ok;

   function automatic logic signed [LVL_W-1:0] clamp_lvl(
      input logic signed [LVL_W-1:0] v,
      input logic signed [LVL_W+5:0] l);
      logic signed [LVL_W+5:0] w;
      logic signed [LVL_W+5:0] nl;
      w = {{6{v[LVL_W-1]}}, v};
      nl = -l;
      if (w > l)
         return l[LVL_W-1:0];
      else if (w < nl)
         return nl[LVL_W-1:0];
      else
         return v;
   endfunction

   // Range is fixed in divisions, so presets shrink at small scales
   assign lim = $signed({6'h00, mv_per_div_in}) * $signed(22'(CLAMP_DIVS));
   assign mid = ($signed({peak_max_in[LVL_W-1], peak_max_in}) +
                 $signed({peak_min_in[LVL_W-1], peak_min_in})) >>> 1;
   assign mid_ok = (trig_type_in == TRGSQ_TYPE_EDGE) ||
                   ((trig_type_in == TRGSQ_TYPE_PULSE) &&
                    pulse_is_glitch_width_in);

   // Main level only; delayed level kept apart
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         main_level_out <= '0;
      end else if (transistor_logic_preset_in) begin
         main_level_out <= clamp_lvl(TTL_LEVEL_MV, lim);
      end else if (emitter_logic_preset_in) begin
         main_level_out <= clamp_lvl(ECL_LEVEL_MV, lim);
      end else if (midpoint_level_request_in && mid_ok) begin
         main_level_out <= clamp_lvl(mid[LVL_W-1:0], lim);
      end else if (knob_load_in) begin
         main_level_out <= clamp_lvl(knob_level_in, lim);
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in)
         dly_level_out <= '0;
      else if (dly_load_in)
         dly_level_out <= clamp_lvl(dly_level_in, lim);
   end

endmodule

// file: test/trgsq_asserts.sv
// Port-level checks for the trigger sequencer
`timescale 1ns/10ps
module trgsq_asserts
   import trgsq_pkg::*;
(
   input wire logic          mclk_in,
   input wire logic          rst_in,
   input wire logic          run_stop_in,
   input wire logic          force_trig_in,
   input wire logic          fast_persist_in,
   input wire logic          multi_frame_in,
   input wire logic          auto_mode_in,
   input wire logic          trig_event_in,
   input wire logic          dly_enable_in,
   input wire trgsq_src_e    source_in,
   input wire trgsq_cpl_e    coupling_in,
   input wire trgsq_status_s status_out,
   input wire logic          acq_start_out,
   input wire logic          acq_forced_out,
   input wire logic          acq_running_out,
   input wire trgsq_src_e    eff_source_out,
   input wire trgsq_cpl_e    eff_coupling_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   wire fast = fast_persist_in | multi_frame_in;
   a_stop_quiet: assert property (status_out == 3'b000 && !run_stop_in
      |=> !acq_start_out) else $error("start while stopped");
   a_force_go: assert property (status_out == 3'b001 && force_trig_in
      && !run_stop_in && !$past(run_stop_in) && !fast && !dly_enable_in
      |=> acq_start_out && acq_forced_out) else $error("force not taken");
   a_ready_trig: assert property (status_out == 3'b010
      && trig_event_in && !force_trig_in && !run_stop_in && !fast
      && !dly_enable_in && !auto_mode_in && !$past(run_stop_in)
      |=> acq_start_out && !acq_forced_out && status_out == 3'b100)
      else $error("trigger in ready not taken");
   a_trig_busy: assert property (status_out == 3'b100 && !fast
      |=> !acq_start_out) else $error("trigger during busy");
   a_start_trigd: assert property (acq_start_out && !$past(fast)
      |-> status_out == 3'b100 || status_out == 3'b110)
      else $error("start without triggered light");
   a_normal_nf: assert property (!auto_mode_in && !force_trig_in
      |=> !(acq_start_out && acq_forced_out)) else $error("forced in normal");
   a_fast_all: assert property ((fast && acq_running_out) [*2]
      |-> status_out == 3'b111) else $error("fast mode lights wrong");
   a_line_ac: assert property (source_in == TRGSQ_SRC_LINE [*3]
      |-> eff_coupling_out == TRGSQ_CPL_AC) else $error("line not ac");
   a_aux_dc: assert property (source_in == TRGSQ_SRC_AUX [*3]
      |-> eff_coupling_out == TRGSQ_CPL_DC) else $error("aux not dc");
   a_chan_cpl: assert property ((source_in < TRGSQ_SRC_LINE
      && $stable(coupling_in)) [*3] |-> eff_coupling_out == coupling_in)
      else $error("channel coupling not honoured");
   a_src_pass: assert property ($stable(source_in) [*2]
      |-> eff_source_out == source_in) else $error("source not passed");
   c_delayed: cover property (status_out == 3'b110);
   c_forced: cover property (acq_start_out && acq_forced_out);
   c_fast: cover property (status_out == 3'b111);
endmodule

// file: test/trgsq_acq_model.sv
// Acquisition engine model answering fill requests
`timescale 1ns/10ps
module trgsq_acq_model
   import trgsq_pkg::*;
(
   input  wire logic          mclk_in,
   input  wire logic          rst_in,
   input  wire trgsq_status_s status_in,
   input  wire logic          acq_start_in,
   input  wire logic    [7:0] lat_in,
   output logic               pretrig_done_out,
   output logic               posttrig_done_out
);
   logic [7:0] cnt_r;
   logic       busy_r;
   initial begin
      pretrig_done_out = 1'b0;
      posttrig_done_out = 1'b0;
   end
   // Busy also set on delayed wait, in case start comes late
   always @(posedge mclk_in) begin
      #1;
      pretrig_done_out = 1'b0;
      posttrig_done_out = 1'b0;
      if (rst_in) begin
         cnt_r = 8'h00;
         busy_r = 1'b0;
      end else begin
         if (acq_start_in || status_in == 3'b110) begin
            busy_r = 1'b1;
         end
         if (status_in == 3'b001 || (busy_r && status_in == 3'b100)) begin
            cnt_r = cnt_r + 8'h01;
         end else begin
            cnt_r = 8'h00;
         end
         if (cnt_r == lat_in) begin
            pretrig_done_out = (status_in == 3'b001);
            posttrig_done_out = busy_r && status_in == 3'b100;
            busy_r = busy_r && !posttrig_done_out;
            cnt_r = 8'h00;
         end
      end
   end
endmodule

// file: test/tb_top.sv
// Self-checking bench for the trigger sequencer
`timescale 1ns/10ps
module tb_top;
   import trgsq_pkg::*;
   localparam int RS=0, FT=1, SS=2, FR=3, FP=4, MF=5, AM=6, TE=7, DT=8;
   localparam int DE=9, DH=10, KL=11, TT=12, EL=13, MP=14, DL=15, GW=16;
   logic                    mclk_in = 1'b0;
   logic                    rst_in = 1'b1;
   logic             [16:0] ctl = '0;
   logic             [31:0] ho = 32'h0000000a;
   logic             [31:0] dv = 32'h00000008;
   logic             [31:0] to = 32'h00000032;
   trgsq_src_e              src = TRGSQ_SRC_CH1;
   trgsq_cpl_e              cpl = TRGSQ_CPL_DC;
   trgsq_type_e             typ = TRGSQ_TYPE_EDGE;
   logic signed      [15:0] knob = '0, pmax = '0, pmin = '0, dlv = '0;
   logic             [15:0] mvd = 16'h00c8;
   logic              [7:0] lat = 8'h03;
   logic                    pre, post, start, forced, running, single;
   trgsq_status_s           st;
   trgsq_src_e              esrc;
   trgsq_cpl_e              ecpl;
   logic signed      [15:0] mlev, dlev;
   int                      n_fail = 0;
   int                      compares = 0;
   trgsq_top #(.HOLDOFF_MAX(200)) i_dut (
      .mclk_in(mclk_in), .rst_in(rst_in), .run_stop_in(ctl[RS]),
      .force_trig_in(ctl[FT]), .single_seq_in(ctl[SS]),
      .free_run_in(ctl[FR]), .fast_persist_in(ctl[FP]),
      .multi_frame_in(ctl[MF]), .auto_mode_in(ctl[AM]),
      .trig_event_in(ctl[TE]), .dly_trig_event_in(ctl[DT]),
      .dly_enable_in(ctl[DE]), .pretrig_done_in(pre),
      .posttrig_done_in(post), .default_holdoff_in(ctl[DH]),
      .holdoff_cycles_in(ho), .div_cycles_in(dv),
      .auto_timeout_cycles_in(to), .source_in(src), .coupling_in(cpl),
      .knob_level_in(knob), .knob_load_in(ctl[KL]),
      .transistor_logic_preset_in(ctl[TT]),
      .emitter_logic_preset_in(ctl[EL]),
      .midpoint_level_request_in(ctl[MP]), .trig_type_in(typ),
      .pulse_is_glitch_width_in(ctl[GW]), .peak_max_in(pmax),
      .peak_min_in(pmin), .mv_per_div_in(mvd), .dly_level_in(dlv),
      .dly_load_in(ctl[DL]), .status_out(st), .acq_start_out(start),
      .acq_forced_out(forced), .acq_running_out(running),
      .single_mode_out(single), .eff_source_out(esrc),
      .eff_coupling_out(ecpl), .main_level_out(mlev),
      .dly_level_out(dlev));
   trgsq_acq_model i_acq (
      .mclk_in(mclk_in), .rst_in(rst_in), .status_in(st),
      .acq_start_in(start), .lat_in(lat), .pretrig_done_out(pre),
      .posttrig_done_out(post));
   initial forever #25 mclk_in = ~mclk_in;
   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge mclk_in);
         #1;
      end
   endtask
   task automatic pulse(input int b);
      ctl[b] = 1'b1;
      cyc(1);
      ctl[b] = 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wst(input logic [2:0] s);
      int n;
      n = 0;
      while (st !== s && n < 3000) begin
         cyc(1);
         n++;
      end
      chk(st, s);
   endtask
   // Cycles from trigger to next fill; only differences are judged
   task automatic hlen(output int n);
      wst(3'b010);
      pulse(TE);
      n = 0;
      while (st !== 3'b001 && n < 3000) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic alen(output int n);
      wst(3'b010);
      n = 0;
      while (start !== 1'b1 && n < 3000) begin
         cyc(1);
         n++;
      end
      chk({start, forced}, 2'b11);
   endtask
   task automatic t_start;
      chk(st, 3'b000);
      chk({start, running, single}, 3'b000);
      chk(mlev, 16'sh0000);
      chk({esrc, ecpl}, {TRGSQ_SRC_CH1, TRGSQ_CPL_DC});
      pulse(FT);
      cyc(3);
      chk({st, running, start}, 5'b00000);
      pulse(RS);
      wst(3'b001);
      pulse(FT);
      chk({start, forced}, 2'b11);
      chk(st, 3'b100);
      pulse(FT);
      chk(start, 1'b0);
      $display("test start done");
   endtask
   task automatic t_hold;
      int a, b;
      int hv[5] = '{30, 0, 1000, 1000, 1000};
      int dvv[5] = '{8, 8, 8, 8, 12};
      int ex[5] = '{20, -5, 190, 30, 50};
      hlen(a);
      for (int i = 0; i < 5; i++) begin
         ho = hv[i];
         dv = dvv[i];
         ctl[DH] = (i > 2);
         hlen(b);
         chk(b - a, ex[i]);
      end
      $display("test holdoff done");
   endtask
   task automatic t_auto;
      int a, b;
      ctl[DH] = 1'b0;
      ho = 32'h0000000a;
      wst(3'b010);
      cyc(100);
      chk(st, 3'b010);
      to = 32'h00000064;
      ctl[AM] = 1'b1;
      alen(a);
      alen(a);
      to = 32'h0000008c;
      alen(b);
      alen(b);
      chk(b - a, 40);
      ctl[AM] = 1'b0;
      $display("test auto done");
   endtask
   task automatic t_dly;
      lat = 8'h08;
      ctl[DE] = 1'b1;
      wst(3'b010);
      pulse(TE);
      chk(st, 3'b110);
      pulse(FT);
      cyc(5);
      chk(st, 3'b110);
      pulse(DT);
      chk(st, 3'b100);
      wst(3'b001);
      ctl[DE] = 1'b0;
      lat = 8'h03;
      $display("test delayed done");
   endtask
   task automatic t_single;
      wst(3'b010);
      pulse(SS);
      chk(single, 1'b1);
      pulse(TE);
      wst(3'b000);
      pulse(RS);
      wst(3'b010);
      pulse(TE);
      wst(3'b000);
      pulse(FR);
      chk(single, 1'b0);
      ctl[FP] = 1'b1;
      pulse(SS);
      pulse(RS);
      cyc(1);
      chk(single, 1'b0);
      chk(st, 3'b111);
      ctl[FP] = 1'b0;
      ctl[MF] = 1'b1;
      cyc(3);
      chk(st, 3'b111);
      ctl[MF] = 1'b0;
      $display("test single done");
   endtask
   task automatic t_cpl;
      for (int i = 0; i < 7; i++) begin
         src = trgsq_src_e'(i % 6);
         cpl = trgsq_cpl_e'((i + 3) % 5);
         cyc(3);
         chk(esrc, src);
         chk(ecpl, src == TRGSQ_SRC_LINE ? TRGSQ_CPL_AC :
            src == TRGSQ_SRC_AUX ? TRGSQ_CPL_DC : cpl);
      end
      $display("test coupling done");
   endtask
   task automatic t_lvl;
      pulse(TT);
      cyc(2);
      chk(mlev, TTL_LEVEL_MV);
      pulse(EL);
      cyc(2);
      chk(mlev, ECL_LEVEL_MV);
      mvd = 16'h0064;
      pulse(TT);
      cyc(2);
      chk(mlev, 16'sh04b0);
      pulse(EL);
      cyc(2);
      chk(mlev, -16'sh04b0);
      mvd = 16'h00c8;
      pmax = 16'sh03e8;
      pmin = -16'sh00c8;
      knob = 16'sh012c;
      ctl[GW] = 1'b1;
      // Edge and pulse take the midpoint, logic and video leave it
      for (int i = 0; i < 4; i++) begin
         typ = trgsq_type_e'(i);
         pulse(KL);
         pulse(MP);
         cyc(2);
         chk(mlev, i < 2 ? 16'sh0190 : 16'sh012c);
      end
      dlv = 16'sh01f4;
      pulse(DL);
      cyc(2);
      chk({dlev, mlev}, {16'sh01f4, 16'sh012c});
      knob = 16'sh0064;
      pulse(KL);
      cyc(2);
      chk({dlev, mlev}, {16'sh01f4, 16'sh0064});
      $display("test level done");
   endtask
   task automatic report_and_stop;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk_in);
      n_fail++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge mclk_in);
      #1;
      rst_in = 1'b0;
      t_start();
      t_hold();
      t_auto();
      t_dly();
      t_single();
      t_cpl();
      t_lvl();
      report_and_stop();
   end
endmodule
bind trgsq_top trgsq_asserts i_chk (
   .mclk_in(mclk_in), .rst_in(rst_in), .run_stop_in(run_stop_in),
   .force_trig_in(force_trig_in), .fast_persist_in(fast_persist_in),
   .multi_frame_in(multi_frame_in), .auto_mode_in(auto_mode_in),
   .trig_event_in(trig_event_in), .dly_enable_in(dly_enable_in),
   .source_in(source_in), .coupling_in(coupling_in),
   .status_out(status_out), .acq_start_out(acq_start_out),
   .acq_forced_out(acq_forced_out), .acq_running_out(acq_running_out),
   .eff_source_out(eff_source_out),
   .eff_coupling_out(eff_coupling_out));
